// File: rtl/sph_top.sv
// serial port with line handshake, fixed 11 bit frames
// Contract
// - each character is one start bit, eight data or parity bits and two stop bits.
// - data is seven bits plus even or odd parity, or eight bits without parity.
// - transmit and receive share one of the rates 1200, 2400, 4800 or 9600 baud.
// - ready-to-receive drops when the input buffer is full and returns when space frees.
// - ready-to-receive stays low from a processed query until its response is sent.
// - each character waits for the host ready input, ready-to-receive low meanwhile.
// - a received control-C aborts work in progress and discards pending output.
// - each response ends with exactly one newline character.
`timescale 1ns/1ps
`default_nettype none
module sph_top
    import sph_pkg::*;
#(
    parameter logic [15:0] BIT_CYC_1200 = 16'(sph_pkg::CLK_HZ / sph_pkg::BAUD_1200),
    parameter logic [15:0] BIT_CYC_2400 = 16'(sph_pkg::CLK_HZ / sph_pkg::BAUD_2400),
    parameter logic [15:0] BIT_CYC_4800 = 16'(sph_pkg::CLK_HZ / sph_pkg::BAUD_4800),
    parameter logic [15:0] BIT_CYC_9600 = 16'(sph_pkg::CLK_HZ / sph_pkg::BAUD_9600)
) (
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       rxd_in,
    input  wire logic       dsr_in,
    output logic            txd_out,
    output logic            dtr_out,
    input  wire logic [1:0] baud_sel_in,
    input  wire logic       parity_en_in,
    input  wire logic       parity_odd_in,
    output logic [7:0]      rx_data_out,
    output logic            rx_perr_out,
    output logic            rx_ferr_out,
    output logic            rx_valid_out,
    input  wire logic       rx_ready_in,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       tx_last_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    input  wire logic       resp_start_in,
    output logic            clr_out
);
    import sph_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} sph_tx_t;
    typedef enum logic       {RX_IDLE, RX_BIT} sph_rx_t;

    logic [1:0]       rxd_sy_q;
    logic [1:0]       dsr_sy_q;
    logic             rxd_s;
    logic             dsr_s;
    logic [CNT_W-1:0] bit_len;
    sph_rx_t          rx_st_q;
    logic [CNT_W-1:0] rx_cnt_q;
    logic [3:0]       rx_idx_q;
    logic [7:0]       rx_sh_q;
    logic             rx_ferr_q;
    logic             rx_done_q;
    logic [7:0]       rx_char;
    logic             rx_etx;
    logic             rx_push;
    logic [FIFO_W-1:0] fifo_in;
    logic [FIFO_W-1:0] fifo_out;
    logic             fifo_in_rdy;
    sph_tx_t          tx_st_q;
    logic [CNT_W-1:0] tx_cnt_q;
    logic [3:0]       tx_idx_q;
    logic [10:0]      tx_sh_q;
    logic             tx_acc;
    logic             nl_pend_q;
    logic             nl_busy_q;
    logic             resp_pend_q;
    logic [7:0]       tx_char;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rxd_sy_q <= 2'h3;
            dsr_sy_q <= 2'h0;
        end else begin
            rxd_sy_q <= {rxd_sy_q[0], rxd_in};
            dsr_sy_q <= {dsr_sy_q[0], dsr_in};
        end
    end
    assign rxd_s = rxd_sy_q[1];
    assign dsr_s = dsr_sy_q[1];

    always_comb begin
        case (baud_sel_in)
            SEL_1200: bit_len = BIT_CYC_1200;
            SEL_2400: bit_len = BIT_CYC_2400;
            SEL_4800: bit_len = BIT_CYC_4800;
            default:  bit_len = BIT_CYC_9600;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_st_q   <= RX_IDLE;
            rx_cnt_q  <= '0;
            rx_idx_q  <= '0;
            rx_sh_q   <= '0;
            rx_ferr_q <= 1'b0;
            rx_done_q <= 1'b0;
        end else begin
            rx_done_q <= 1'b0;
            case (rx_st_q)
                RX_IDLE: begin
                    if (!rxd_s) begin
                        rx_st_q   <= RX_BIT;
                        rx_cnt_q  <= bit_len >> 1;
                        rx_idx_q  <= '0;
                        rx_ferr_q <= 1'b0;
                    end
                end
                RX_BIT: begin
                    if (rx_cnt_q != '0) begin
                        rx_cnt_q <= rx_cnt_q - 1'b1;
                    end else begin
                        rx_cnt_q <= bit_len - 1'b1;
                        rx_idx_q <= rx_idx_q + 1'b1;
                        if (rx_idx_q == '0 && rxd_s) begin
                            rx_st_q <= RX_IDLE;
                        end else if (rx_idx_q != '0 && rx_idx_q <= PAR_BIT) begin
                            rx_sh_q <= {rxd_s, rx_sh_q[7:1]};
                        end else if (rx_idx_q >= STOP_BIT) begin
                            if (!rxd_s) begin
                                rx_ferr_q <= 1'b1;
                            end
                            if (rx_idx_q == LAST_BIT) begin
                                rx_st_q   <= RX_IDLE;
                                rx_done_q <= 1'b1;
                            end
                        end
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    assign rx_char = parity_en_in ? {1'b0, rx_sh_q[6:0]} : rx_sh_q;
    assign rx_etx  = (rx_char == CHAR_ETX);
    assign rx_push = rx_done_q && !rx_etx;
    assign fifo_in[7:0]     = rx_char;
    assign fifo_in[PERR_POS] = parity_en_in && (^rx_sh_q ^ parity_odd_in);
    assign fifo_in[FERR_POS] = rx_ferr_q;

    sph_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rx_fifo (
        .clk_in        (ref_clk_in),
        .rst_in        (sys_rst_in),
        .in_data_in    (fifo_in),
        .in_valid_in   (rx_push),
        .in_ready_out  (fifo_in_rdy),
        .out_data_out  (fifo_out),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in)
    );
    assign rx_data_out = fifo_out[7:0];
    assign rx_perr_out = fifo_out[PERR_POS];
    assign rx_ferr_out = fifo_out[FERR_POS];

    ////////////////////////////////////////////////////////////////////////
    // device clear, response tracking and holdoff
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            clr_out <= 1'b0;
        end else begin
            clr_out <= rx_done_q && rx_etx;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            resp_pend_q <= 1'b0;
        end else if (resp_start_in) begin
            resp_pend_q <= 1'b1;
        end else if (clr_out || (nl_busy_q && tx_st_q == TX_SHIFT
                     && tx_idx_q == LAST_BIT && tx_cnt_q == '0)) begin
            resp_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dtr_out <= 1'b0;
        end else begin
            dtr_out <= fifo_in_rdy && !resp_pend_q
                       && !resp_start_in
                       && !(tx_st_q == TX_WAIT && !dsr_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    assign tx_acc  = tx_st_q == TX_IDLE && tx_ready_out && tx_valid_in
                     && !clr_out;
    assign tx_char = nl_pend_q ? CHAR_NL : tx_data_in;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            nl_pend_q    <= 1'b0;
            tx_ready_out <= 1'b0;
        end else begin
            if (clr_out) begin
                nl_pend_q <= 1'b0;
            end else if (tx_acc && tx_last_in) begin
                nl_pend_q <= 1'b1;
            end else if (tx_st_q == TX_IDLE) begin
                nl_pend_q <= 1'b0;
            end
            tx_ready_out <= tx_st_q == TX_IDLE && !nl_pend_q && !tx_acc
                            && !clr_out;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_st_q   <= TX_IDLE;
            tx_cnt_q  <= '0;
            tx_idx_q  <= '0;
            tx_sh_q   <= '1;
            nl_busy_q <= 1'b0;
            txd_out   <= 1'b1;
        end else begin
            txd_out <= (tx_st_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;
            case (tx_st_q)
                TX_IDLE: begin
                    if (!clr_out && (nl_pend_q || tx_acc)) begin
                        tx_st_q   <= TX_WAIT;
                        nl_busy_q <= nl_pend_q;
                        tx_sh_q   <= {2'h3, parity_en_in ?
                                      (^tx_char[6:0] ^ parity_odd_in) :
                                      tx_char[7], tx_char[6:0], 1'b0};
                    end
                end
                TX_WAIT: begin
                    if (clr_out) begin
                        tx_st_q <= TX_IDLE;
                    end else if (dsr_s) begin
                        tx_st_q  <= TX_SHIFT;
                        tx_cnt_q <= bit_len - 1'b1;
                        tx_idx_q <= '0;
                    end
                end
                TX_SHIFT: begin
                    if (tx_cnt_q != '0) begin
                        tx_cnt_q <= tx_cnt_q - 1'b1;
                    end else begin
                        tx_cnt_q <= bit_len - 1'b1;
                        tx_idx_q <= tx_idx_q + 1'b1;
                        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                        if (tx_idx_q == LAST_BIT) begin
                            tx_st_q <= TX_IDLE;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_frame_end;
        tx_st_q == TX_SHIFT && tx_idx_q == LAST_BIT && tx_cnt_q == '0
        |=> tx_st_q == TX_IDLE ##1 txd_out;
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("frame not ended after eleven bits");

    property p_stop_high;
        tx_st_q == TX_SHIFT && tx_idx_q >= STOP_BIT |=> txd_out;
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("stop bit not high");

    property p_parity;
        tx_st_q == TX_WAIT && parity_en_in
        |-> tx_sh_q[8] == (^tx_sh_q[7:1] ^ parity_odd_in);
    endproperty
    a_parity: assert property (p_parity)
        else $error("wrong transmit parity bit");

    property p_bit_len;
        tx_st_q == TX_SHIFT |-> tx_cnt_q < bit_len;
    endproperty
    a_bit_len: assert property (p_bit_len)
        else $error("bit counter beyond bit time");

    property p_dtr_full;
        !fifo_in_rdy |=> !dtr_out;
    endproperty
    a_dtr_full: assert property (p_dtr_full)
        else $error("ready-to-receive high with buffer full");

    property p_dtr_resp;
        resp_start_in |=> !dtr_out [*2];
    endproperty
    a_dtr_resp: assert property (p_dtr_resp)
        else $error("ready-to-receive high with response pending");

    property p_dsr_hold;
        tx_st_q == TX_WAIT && !dsr_s && !clr_out
        |=> tx_st_q == TX_WAIT && !dtr_out;
    endproperty
    a_dsr_hold: assert property (p_dsr_hold)
        else $error("character started without host ready");

    property p_ctrl_c;
        rx_done_q && rx_etx |-> !rx_push ##1 clr_out ##1 !nl_pend_q;
    endproperty
    a_ctrl_c: assert property (p_ctrl_c)
        else $error("control-C not handled as device clear");

    property p_newline;
        tx_st_q == TX_IDLE && nl_pend_q && !clr_out
        |=> tx_st_q == TX_WAIT && nl_busy_q && !nl_pend_q
            && tx_sh_q[7:1] == CHAR_NL[6:0];
    endproperty
    a_newline: assert property (p_newline)
        else $error("newline not appended after response");

    property p_ferr;
        rx_st_q == RX_BIT && rx_idx_q == STOP_BIT && rx_cnt_q == '0 && !rxd_s
        |=> rx_ferr_q;
    endproperty
    a_ferr: assert property (p_ferr)
        else $error("low stop bit not flagged");

    c_ctrl_c:  cover property (clr_out);
    c_dsr_wait: cover property (tx_st_q == TX_WAIT && !dsr_s);
    c_full:    cover property (!fifo_in_rdy);
    c_nl_sent: cover property (nl_busy_q && tx_st_q == TX_SHIFT
                               && tx_idx_q == LAST_BIT);
endmodule : sph_top
`default_nettype wire

// File: common/sph_pkg.sv
// shared constants for the serial port with line handshake
package sph_pkg;
    localparam int unsigned CLK_HZ    = 32'h02fa_f080;
    localparam int unsigned BAUD_1200 = 32'h0000_04b0;
    localparam int unsigned BAUD_2400 = 32'h0000_0960;
    localparam int unsigned BAUD_4800 = 32'h0000_12c0;
    localparam int unsigned BAUD_9600 = 32'h0000_2580;
    localparam int          CNT_W     = 16;
    localparam logic [1:0]  SEL_1200  = 2'h0;
    localparam logic [1:0]  SEL_2400  = 2'h1;
    localparam logic [1:0]  SEL_4800  = 2'h2;
    localparam logic [1:0]  SEL_9600  = 2'h3;
    localparam logic [3:0]  LAST_BIT  = 4'ha;
    localparam logic [3:0]  PAR_BIT   = 4'h8;
    localparam logic [3:0]  STOP_BIT  = 4'h9;
    localparam logic [7:0]  CHAR_NL   = 8'h0a;
    localparam logic [7:0]  CHAR_ETX  = 8'h03;
    localparam int          FIFO_D    = 8;
    localparam int          FIFO_W    = 10;
    localparam int          PERR_POS  = 8;
    localparam int          FERR_POS  = 9;
endpackage : sph_pkg

// File: rtl/sph_fifo.sv
// receive buffer fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module sph_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    output logic      [W-1:0] out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          load;

    assign in_ready_out = (cnt_q != (AW+1)'(D));
    assign push = in_valid_in && in_ready_out;
    assign load = (cnt_q != '0) && (!out_valid_out || out_ready_in);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (load) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end else if (load) begin
            out_valid_out <= 1'b1;
            out_data_out  <= mem_q[rd_q];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_fifo_bound;
        cnt_q <= (AW+1)'(D);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo count exceeds depth");

    property p_fifo_hold;
        out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold)
        else $error("fifo output changed while stalled");
endmodule : sph_fifo
`default_nettype wire

// File: verification/sph_host_model.sv
// host side model: serial frames and line handshake
`timescale 1ns/1ps
`default_nettype none
module sph_host_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] bit_in,
    input  wire logic        txd_in,
    input  wire logic        dtr_in,
    output logic             rxd_out,
    output logic             dsr_out
);
    logic [10:0] got_q[$];
    logic [10:0] f;
    int          n_low;
    initial begin
        rxd_out = 1'b1;
        dsr_out = 1'b1;
        n_low   = 0;
    end
    ////////////////////////////////////////
    // send one frame, lsb first, line left at its last bit (fr[10]) after it
    task automatic send(input logic [10:0] fr);
        if (dtr_in)
            n_low = 0;
        else
            n_low++;
        if (n_low > 10)
            wait (dtr_in);
        for (int i = 0; i < 11; i++) begin
            rxd_out <= fr[i];
            repeat (bit_in) @(posedge clk_in);
        end
    endtask
    // change the ready line and let the port's syncs settle
    task automatic set_dsr(input logic v);
        dsr_out <= v;
        repeat (4) @(posedge clk_in);
    endtask
    ////////////////////////////////////////
    // capture each frame at mid bit
    always begin
        @(negedge txd_in);
        repeat (bit_in / 2) @(posedge clk_in);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd_in;
            if (i < 10)
                repeat (bit_in) @(posedge clk_in);
        end
        got_q.push_back(f);
    end
endmodule // sph_host_model
`default_nettype wire

// File: verification/sph_top_tb.sv
// self-checking bench for the serial port with line handshake
`timescale 1ns/1ps
`default_nettype none
module sph_top_tb;
    import sph_pkg::*;
    localparam logic [15:0] BL [4] = '{16'h0010, 16'h000c, 16'h000a,
                                       16'h0008};
    logic       ref_clk, sys_rst, rxd, dsr, txd, dtr, par_en, par_odd;
    logic       perr, ferr, rx_valid, rx_ready, tx_last, tx_valid;
    logic       tx_ready, resp_start, clr;
    logic [1:0] baud_sel;
    logic [7:0] rx_data, tx_data;
    int         mismatches, n_checks, n_clr, cyc;

    sph_top #(.BIT_CYC_1200(BL[0]), .BIT_CYC_2400(BL[1]),
              .BIT_CYC_4800(BL[2]), .BIT_CYC_9600(BL[3])) dut (
        .ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .rxd_in(rxd),
        .dsr_in(dsr), .txd_out(txd), .dtr_out(dtr),
        .baud_sel_in(baud_sel), .parity_en_in(par_en),
        .parity_odd_in(par_odd), .rx_data_out(rx_data),
        .rx_perr_out(perr), .rx_ferr_out(ferr),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
        .tx_data_in(tx_data), .tx_last_in(tx_last),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .resp_start_in(resp_start), .clr_out(clr));
    sph_host_model host (.clk_in(ref_clk), .bit_in(BL[baud_sel]),
        .txd_in(txd), .dtr_in(dtr), .rxd_out(rxd), .dsr_out(dsr));

    always #10 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task automatic check(input string what, input logic [10:0] exp,
                         input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_lv(ref logic s, input logic v, input int n);
        int i;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (s !== v && i < n);
        check("level", 11'(v), 11'(s));
    endtask
    task automatic put(input logic [7:0] d, input logic [1:0] st);
        host.send({st, d, 1'b0});
    endtask
    task automatic take(input logic [7:0] d, input logic pe, fe);
        @(posedge ref_clk);
        wait_lv(rx_valid, 1'b1, 400);
        check("rx_data", 11'(d), 11'(rx_data));
        check("rx_flags", 11'({pe, fe}), 11'({perr, ferr}));
        rx_ready <= 1'b1;
        @(posedge ref_clk);
        rx_ready <= 1'b0;
    endtask
    task automatic offer(input logic [7:0] d, input logic last);
        tx_data  <= d;
        tx_last  <= last;
        tx_valid <= 1'b1;
        wait_lv(tx_ready, 1'b1, 4000);
        tx_valid <= 1'b0;
    endtask
    task automatic get_frame(input logic [10:0] fr);
        int i;
        i = 0;
        while (host.got_q.size() == 0 && i < 4000) begin
            @(posedge ref_clk);
            i++;
        end
        check("tx_frame", fr,
              host.got_q.size() > 0 ? host.got_q.pop_front() : 11'h7ff);
        repeat (20) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////
    task automatic t_rates();
        logic [7:0] d;
        for (int s = 0; s < 4; s++) begin
            d = 8'ha5 ^ 8'(s);
            baud_sel <= 2'(s);
            @(posedge ref_clk);
            put(d, 2'b11);
            take(d, 1'b0, 1'b0);
            offer(d, 1'b0);
            get_frame({2'b11, d, 1'b0});
        end
        $display("test rates done");
    endtask
    task automatic t_parity();
        logic [6:0] d;
        logic       p;
        d = 7'h35;
        par_en <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            par_odd <= k[1];
            @(posedge ref_clk);
            p = ^d ^ k[1];
            put({p ^ k[0], d}, 2'b11);
            take({1'b0, d}, k[0], 1'b0);
            offer({1'b1, d}, 1'b0);
            get_frame({2'b11, p, d, 1'b0});
        end
        par_en <= 1'b0;
        @(posedge ref_clk);
        put(8'h3c, 2'b10);
        take(8'h3c, 1'b0, 1'b1);
        $display("test parity done");
    endtask
    task automatic t_full();
        for (int i = 0; i < 10; i++)
            put(8'h40 + 8'(i), 2'b11);
        check("dtr", 11'h000, 11'(dtr));
        for (int i = 0; i < 9; i++)
            take(8'h40 + 8'(i), 1'b0, 1'b0);
        @(posedge ref_clk);
        check("rx_valid", 11'h000, 11'(rx_valid));
        wait_lv(dtr, 1'b1, 8);
        $display("test full done");
    endtask
    task automatic t_resp();
        resp_start <= 1'b1;
        @(posedge ref_clk);
        resp_start <= 1'b0;
        wait_lv(dtr, 1'b0, 4);
        offer(8'h52, 1'b1);
        get_frame({2'b11, 8'h52, 1'b0});
        check("dtr", 11'h000, 11'(dtr));
        get_frame({2'b11, CHAR_NL, 1'b0});
        wait_lv(dtr, 1'b1, 8);
        repeat (200) @(posedge ref_clk);
        check("frames", 11'h000, 11'(host.got_q.size()));
        $display("test resp done");
    endtask
    task automatic t_hold();
        int c;
        host.set_dsr(1'b0);
        offer(8'h44, 1'b0);
        repeat (100) @(posedge ref_clk);
        check("txd", 11'h001, 11'(txd));
        check("dtr", 11'h000, 11'(dtr));
        host.set_dsr(1'b1);
        get_frame({2'b11, 8'h44, 1'b0});
        host.set_dsr(1'b0);
        offer(8'h21, 1'b1);
        c = n_clr;
        put(CHAR_ETX, 2'b11);
        repeat (8) @(posedge ref_clk);
        check("clr", 11'(c + 1), 11'(n_clr));
        check("rx_valid", 11'h000, 11'(rx_valid));
        host.set_dsr(1'b1);
        repeat (300) @(posedge ref_clk);
        check("frames", 11'h000, 11'(host.got_q.size()));
        wait_lv(tx_ready, 1'b1, 4);
        wait_lv(dtr, 1'b1, 4);
        $display("test hold done");
    endtask
    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (clr === 1'b1)
            n_clr++;
        if (cyc == 40000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        ref_clk    = 1'b0;
        sys_rst    = 1'b1;
        baud_sel   = 2'h3;
        par_en     = 1'b0;
        par_odd    = 1'b0;
        rx_ready   = 1'b0;
        tx_data    = 8'h00;
        tx_last    = 1'b0;
        tx_valid   = 1'b0;
        resp_start = 1'b0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_lv(dtr, 1'b1, 4);
        repeat (2) @(posedge ref_clk);
        t_rates();
        t_parity();
        t_full();
        t_resp();
        t_hold();
        give_verdict();
    end
endmodule // sph_top_tb
`default_nettype wire
